// File: pevirq_led.sv
// Purpose: drives one indicator from its four-bit selector
// Assumes: status inputs synchronous to mclk; ticks are one-cycle enables
// Notes:   stretch length is shortened through STRETCH_CYC in simulation
`timescale 1ns/100ps
`default_nettype none
`include "pevirq_map.svh"
module pevirq_led #(
	parameter int STRETCH_CYC = `PEV_STRETCH_MS * (`PEV_CLK_HZ / 1000)
) (
	// clock and reset
	input  wire logic   mclk,
	input  wire logic   arst_n,
	// selector, status and result
	pevirq_led_if.led   lif
);
	localparam logic [23:0] STR_LOAD = 24'(STRETCH_CYC);

	pevirq_pkg::pevirq_led_st_t r;
	pevirq_pkg::pevirq_led_st_t n;

	always_comb begin
		logic evt;
		logic prim;
		logic comb_mode;
		logic active;
		evt       = 1'b0;
		prim      = 1'b0;
		comb_mode = 1'b0;
		active    = 1'b0;
		n         = r;
		case (lif.sel)
			`PEV_LED_TX:     evt = lif.tx;
			`PEV_LED_RX:     evt = lif.rx;
			`PEV_LED_COL:    evt = lif.col;
			`PEV_LED_ACT:    evt = lif.rx | lif.tx;
			`PEV_LED_LNKRX: begin
				evt = lif.rx;
				prim = lif.link;
				comb_mode = 1'b1;
			end
			`PEV_LED_LNKACT: begin
				evt = lif.rx | lif.tx;
				prim = lif.link;
				comb_mode = 1'b1;
			end
			`PEV_LED_DUPCOL: begin
				evt = lif.col;
				prim = lif.dup;
				comb_mode = 1'b1;
			end
			default: evt = 1'b0;
		endcase
		// stretching is unconditional here, there is no stretch switch
		if (evt) begin
			n.str = STR_LOAD;
		end else if (r.str != 24'h000000) begin
			n.str = r.str - 24'h000001;
		end
		active = evt | (r.str != 24'h000000);
		if (lif.fast_tick) begin
			n.fast_q = ~r.fast_q;
			n.blink_q = active ? ~r.blink_q : 1'b0;
		end
		if (lif.slow_tick) begin
			n.slow_q = ~r.slow_q;
		end
		case (lif.sel)
			`PEV_LED_SPEED: n.led_q = lif.speed;
			`PEV_LED_LINK:  n.led_q = lif.link;
			`PEV_LED_DUP:   n.led_q = lif.dup;
			`PEV_LED_ON:    n.led_q = 1'b1;
			`PEV_LED_OFF:   n.led_q = 1'b0;
			`PEV_LED_FAST:  n.led_q = r.fast_q;
			`PEV_LED_SLOW:  n.led_q = r.slow_q;
			`PEV_LED_UNUSED6, `PEV_LED_UNUSEDF: n.led_q = 1'b0;
			default: n.led_q = comb_mode ? (active ? r.blink_q : prim) : active;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign lif.led_on = r.led_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_test_on_off: assert property ((lif.sel == `PEV_LED_ON) ##1 (lif.sel == `PEV_LED_OFF)
		|=> !lif.led_on && $past(lif.led_on)) else $error("test on/off code not obeyed");
	a_unused_dark: assert property ((lif.sel == `PEV_LED_UNUSED6)
		|| (lif.sel == `PEV_LED_UNUSEDF) |=> !lif.led_on) else $error("unused code lit the indicator");
	a_link_solid: assert property ((lif.sel == `PEV_LED_LNKRX) && lif.link && !lif.rx
		&& (r.str == 24'h000000) |=> lif.led_on) else $error("link not solid in combined mode");
	a_dup_solid: assert property ((lif.sel == `PEV_LED_DUPCOL) && lif.dup && !lif.col
		&& (r.str == 24'h000000) |=> lif.led_on) else $error("duplex not solid in combined mode");
	a_stretch_load: assert property ((lif.sel == `PEV_LED_TX) && lif.tx |=> r.str == STR_LOAD
		##1 (lif.led_on && (r.str != 24'h000000))) else $error("event not stretched");
	c_combined_blink: cover property ((lif.sel == `PEV_LED_LNKACT) && lif.tx ##1 lif.fast_tick);
	c_link_shown: cover property ((lif.sel == `PEV_LED_LINK) && lif.link ##1 lif.led_on);
endmodule : pevirq_led
`default_nettype wire

// File: pevirq_led_if.sv
// Purpose: carries one indicator's selector, line status and blink ticks
// Assumes: one instance per indicator output
// Notes:   led_on comes from a flip-flop in the indicator module
`timescale 1ns/100ps
`default_nettype none
interface pevirq_led_if;
	logic [3:0] sel;
	logic       speed;
	logic       tx;
	logic       rx;
	logic       col;
	logic       link;
	logic       dup;
	logic       fast_tick;
	logic       slow_tick;
	logic       led_on;

	modport src (output sel, speed, tx, rx, col, link, dup, fast_tick, slow_tick, input led_on);
	modport led (input sel, speed, tx, rx, col, link, dup, fast_tick, slow_tick, output led_on);
endinterface : pevirq_led_if
`default_nettype wire

// File: pevirq_map.svh
// Purpose: named offsets, fields, reset values, codes and times of the event irq / indicator block
// Assumes: included by its bare name from every design file that needs it
// Notes:   definitions only
`ifndef PEVIRQ_MAP_SVH
`define PEVIRQ_MAP_SVH

// register offsets on the management serial interface
`define PEV_REG_MASK     5'h12
`define PEV_REG_FLAGS    5'h13
`define PEV_REG_LEDSEL   5'h14

// field positions
`define PEV_B_AN         7
`define PEV_B_SPD        6
`define PEV_B_DUP        5
`define PEV_B_LNK        4
`define PEV_B_PEND       2
`define PEV_B_GLOBAL_IRQ_ENABLE      1
`define PEV_B_FORCE_TEST_IRQ       0
`define PEV_EVT_HI       7
`define PEV_EVT_LO       4
`define PEV_LEDA_HI      15
`define PEV_LEDA_LO      12
`define PEV_LEDB_HI      11
`define PEV_LEDB_LO      8

// writable bits and reset values
`define PEV_MASK_WMASK   16'h00f3
`define PEV_MASK_RST     16'h0000
`define PEV_LEDA_RST     4'h0
`define PEV_LEDB_RST     4'h4

// frame fields
`define PEV_PRE_LEN      6'h20
`define PEV_OP_LAST      6'h01
`define PEV_ADDR_LAST    6'h09
`define PEV_DATA_LAST    6'h0f
`define PEV_OP_RD        2'h2
`define PEV_OP_WR        2'h1

// indicator selector codes
`define PEV_LED_SPEED    4'h0
`define PEV_LED_TX       4'h1
`define PEV_LED_RX       4'h2
`define PEV_LED_COL      4'h3
`define PEV_LED_LINK     4'h4
`define PEV_LED_DUP      4'h5
`define PEV_LED_UNUSED6  4'h6
`define PEV_LED_ACT      4'h7
`define PEV_LED_ON       4'h8
`define PEV_LED_OFF      4'h9
`define PEV_LED_FAST     4'ha
`define PEV_LED_SLOW     4'hb
`define PEV_LED_LNKRX    4'hc
`define PEV_LED_LNKACT   4'hd
`define PEV_LED_DUPCOL   4'he
`define PEV_LED_UNUSEDF  4'hf

// timing
`define PEV_CLK_HZ       50000000
`define PEV_STRETCH_MS   30
`define PEV_BLINK_MS     50
`define PEV_SLOW_RATIO   3'h5

`endif

// File: pevirq_mgmt_master.sv
// Purpose: station management controller that runs frames on mdc / mdio
// Assumes: the shared data line has a pull-up; mdc period is six mclk cycles
// Notes:   mdc stands low between frames; the line floats high once released
`timescale 1ns/100ps
`default_nettype none
`include "pevirq_map.svh"
module pevirq_mgmt_master (
	// clock
	input  wire logic mclk,
	// management serial interface
	output logic      mdc,
	output wire logic mdio_in,
	input  wire logic mdio_out,
	input  wire logic mdio_oe
);
	logic drv;
	logic en;

	// released line shows the pull-up, never a stale bit
	assign mdio_in = en ? drv : (mdio_oe ? mdio_out : 1'b1);

	initial begin
		mdc = 1'b0;
		drv = 1'b1;
		en  = 1'b0;
	end

	// one whole frame: preamble, start, op, addresses, turnaround, 16 data bits
	task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rdat);
		logic [63:0] frm;
		logic [15:0] wv;
		int          i;
		// unused mask bits always go out as zero
		wv = (ra == `PEV_REG_MASK) ? (wd & `PEV_MASK_WMASK) : wd;
		frm = {32'hffffffff, 2'b01, rd ? `PEV_OP_RD : `PEV_OP_WR, pa, ra, 2'b10, wv};
		rdat = 16'h0000;
		for (i = 63; i >= 0; i--) begin
			@(negedge mclk);
			mdc = 1'b0;
			en  = !(rd && i < 18);
			drv = frm[i];
			repeat (3) @(negedge mclk);
			if (rd && i < 16) begin
				rdat[i] = mdio_in;
			end
			mdc = 1'b1;
			repeat (2) @(negedge mclk);
		end
		@(negedge mclk);
		mdc = 1'b0;
		en  = 1'b0;
	endtask : xfer
endmodule : pevirq_mgmt_master
`default_nettype wire

// File: pevirq_pkg.sv
// Purpose: types of the event irq / indicator block
// Assumes: nothing is imported, users write pevirq_pkg::name
// Notes:   pevirq_top and pevirq_led each keep their whole state in one of these structs
package pevirq_pkg;

	typedef enum logic [2:0] {
		S_PRE  = 3'b000,
		S_ST   = 3'b001,
		S_OP   = 3'b010,
		S_ADDR = 3'b011,
		S_TA   = 3'b100,
		S_DATA = 3'b101
	} pevirq_state_t;

	typedef struct packed {
		pevirq_state_t st;
		logic [5:0]    cnt;
		logic [15:0]   sh;
		logic          rd;
		logic          hit;
		logic [4:0]    ra;
		logic          mdc_q;
		logic [15:0]   mask_reg;
		logic [3:0]    flags_reg;
		logic [3:0]    snap;
		logic [3:0]    lvl_q;
		logic [7:0]    ledsel_reg;
		logic          irq_reg;
		logic          mdio_out;
		logic          mdio_oe;
		logic [23:0]   div;
		logic [2:0]    slow_cnt;
		logic          fast_tick;
		logic          slow_tick;
	} pevirq_top_st_t;

	typedef struct packed {
		logic [23:0] str;
		logic        blink_q;
		logic        fast_q;
		logic        slow_q;
		logic        led_q;
	} pevirq_led_st_t;

endpackage : pevirq_pkg

// File: pevirq_top.sv
// Purpose: event interrupt mask, change flags and indicator selection behind the management port
// Assumes: mdc and mdio_in synchronous to mclk, mdc well below mclk/4
// Notes:   mgmt_irq_out is active high; the pin driver may invert it
//
// Overview of operation
// - autoneg-done event reaches the interrupt only with its mask bit set.
// - speed change reaches the interrupt only with its mask bit set.
// - duplex change reaches the interrupt only with its mask bit set.
// - link change reaches the interrupt only with its mask bit set.
// - global enable gates all events; resets to zero.
// - test bit forces the interrupt active; clearing it restores normal behaviour.
// - read-only self-clearing flag reports autonegotiation completed.
// - speed-change flag sets on change, held until status read clears it.
// - duplex-change flag sets on change, held until status read clears it.
// - link-change flag sets on change, held until status read clears it.
// - read-only status bit shows interrupt pending.
// - first indicator four-bit selector resets to speed display.
// - transmit, receive, collision stretched; link and duplex continuous.
// - codes 1000-1011 give on, off, fast blink, slow blink.
// - code 0111 shows stretched activity; 0110 and 1111 show nothing.
// - code 1100 combines link and receive, stretched.
// - code 1101 combines link and activity, 1110 duplex and collision.
// - second indicator uses same codes, resets to link display.
// - link-combined modes solid while link up, blink on events.
// - duplex-collision mode solid at full duplex, blinks on collision.
// - combined modes always stretch events.
`timescale 1ns/100ps
`default_nettype none
`include "pevirq_map.svh"
module pevirq_top #(
	parameter int STRETCH_CYC = `PEV_STRETCH_MS * (`PEV_CLK_HZ / 1000),
	parameter int BLINK_CYC   = `PEV_BLINK_MS * (`PEV_CLK_HZ / 1000)
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// management serial interface
	input  wire logic       mdc,
	input  wire logic       mdio_in,
	output logic            mdio_out,
	output logic            mdio_oe,
	input  wire logic [4:0] phy_addr,
	// line status
	input  wire logic       link_up,
	input  wire logic       full_duplex,
	input  wire logic       speed_100,
	input  wire logic       autoneg_done,
	input  wire logic       tx_active,
	input  wire logic       rx_active,
	input  wire logic       collision,
	// results
	output logic            mgmt_irq_out,
	output logic            indicator_a,
	output logic            indicator_b
);
	localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYC - 1);

	pevirq_pkg::pevirq_top_st_t r;
	pevirq_pkg::pevirq_top_st_t n;
	pevirq_led_if               led_a ();
	pevirq_led_if               led_b ();

	always_comb begin
		logic [3:0]  chg;
		logic [3:0]  clr;
		logic [4:0]  reg_sel;
		logic [15:0] rdata;
		logic [15:0] wdata;
		logic        edge_up;
		n       = r;
		rdata   = 16'h0000;
		clr     = 4'h0;
		edge_up = mdc & ~r.mdc_q;
		reg_sel = {r.sh[3:0], mdio_in};
		wdata   = {r.sh[14:0], mdio_in};
		// autoneg latches on completion, the others on any level change
		chg = {autoneg_done & ~r.lvl_q[3], speed_100 ^ r.lvl_q[2],
			full_duplex ^ r.lvl_q[1], link_up ^ r.lvl_q[0]};
		case (reg_sel)
			`PEV_REG_MASK:   rdata = r.mask_reg & `PEV_MASK_WMASK;
			`PEV_REG_FLAGS:  rdata = {8'h00, r.flags_reg, 1'b0, r.irq_reg, 2'b00};
			`PEV_REG_LEDSEL: rdata = {r.ledsel_reg, 8'h00};
			default:         rdata = 16'h0000;
		endcase
		n.mdc_q = mdc;
		n.lvl_q = {autoneg_done, speed_100, full_duplex, link_up};
		n.fast_tick = 1'b0;
		n.slow_tick = 1'b0;
		if (edge_up) begin
			case (r.st)
				pevirq_pkg::S_PRE: begin
					// a start bit counts only after a full run of ones
					if (mdio_in) begin
						if (r.cnt != `PEV_PRE_LEN) n.cnt = r.cnt + 6'h01;
					end else begin
						n.cnt = 6'h00;
						if (r.cnt == `PEV_PRE_LEN) n.st = pevirq_pkg::S_ST;
					end
				end
				pevirq_pkg::S_ST: begin
					n.st = mdio_in ? pevirq_pkg::S_OP : pevirq_pkg::S_PRE;
					n.cnt = 6'h00;
				end
				pevirq_pkg::S_OP: begin
					n.sh = wdata;
					n.cnt = r.cnt + 6'h01;
					if (r.cnt == `PEV_OP_LAST) begin
						n.cnt = 6'h00;
						n.rd = (wdata[1:0] == `PEV_OP_RD);
						n.st = ((wdata[1:0] == `PEV_OP_RD) || (wdata[1:0] == `PEV_OP_WR)) ?
							pevirq_pkg::S_ADDR : pevirq_pkg::S_PRE;
					end
				end
				pevirq_pkg::S_ADDR: begin
					n.sh = wdata;
					n.cnt = r.cnt + 6'h01;
					if (r.cnt == `PEV_ADDR_LAST) begin
						n.cnt = 6'h00;
						n.hit = (r.sh[8:4] == phy_addr);
						n.ra = reg_sel;
						n.sh = rdata;
						// remember what this read reports so only those bits get cleared
						n.snap = r.flags_reg;
						n.st = pevirq_pkg::S_TA;
					end
				end
				pevirq_pkg::S_TA: begin
					// take the line only for a read addressed to this device
					if (r.cnt == 6'h00) begin
						n.cnt = 6'h01;
						n.mdio_oe = r.rd & r.hit;
						n.mdio_out = 1'b0;
					end else begin
						n.cnt = 6'h00;
						n.st = pevirq_pkg::S_DATA;
						if (r.rd) begin
							n.mdio_out = r.hit & r.sh[15];
							n.sh = {r.sh[14:0], 1'b0};
						end
					end
				end
				pevirq_pkg::S_DATA: begin
					n.cnt = r.cnt + 6'h01;
					if (r.rd) begin
						n.mdio_out = r.hit & r.sh[15];
						n.sh = {r.sh[14:0], 1'b0};
					end else begin
						n.sh = wdata;
					end
					// writes commit on the last bit, so a cut frame changes nothing
					if (r.cnt == `PEV_DATA_LAST) begin
						n.st = pevirq_pkg::S_PRE;
						n.cnt = 6'h00;
						n.mdio_oe = 1'b0;
						n.mdio_out = 1'b0;
						if (r.hit && r.rd && (r.ra == `PEV_REG_FLAGS)) clr = r.snap;
						if (r.hit && !r.rd && (r.ra == `PEV_REG_MASK))
							n.mask_reg = wdata & `PEV_MASK_WMASK;
						if (r.hit && !r.rd && (r.ra == `PEV_REG_LEDSEL))
							n.ledsel_reg = wdata[`PEV_LEDA_HI:`PEV_LEDB_LO];
					end
				end
				default: begin
					n.st = pevirq_pkg::S_PRE;
					n.cnt = 6'h00;
					n.mdio_oe = 1'b0;
				end
			endcase
		end
		// set wins over the read clear
		n.flags_reg = (r.flags_reg & ~clr) | chg;
		// registered so the pin and the pending bit cannot glitch
		n.irq_reg = (r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE]
			& |(r.flags_reg & r.mask_reg[`PEV_EVT_HI:`PEV_EVT_LO]))
			| r.mask_reg[`PEV_B_FORCE_TEST_IRQ];
		// shared blink timebase, one enable pulse per half period
		if (r.div == BLINK_LAST) begin
			n.div = 24'h000000;
			n.fast_tick = 1'b1;
			if (r.slow_cnt == `PEV_SLOW_RATIO - 3'h1) begin
				n.slow_cnt = 3'h0;
				n.slow_tick = 1'b1;
			end else begin
				n.slow_cnt = r.slow_cnt + 3'h1;
			end
		end else begin
			n.div = r.div + 24'h000001;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
			r.mask_reg <= `PEV_MASK_RST;
			r.ledsel_reg <= {`PEV_LEDA_RST, `PEV_LEDB_RST};
		end else begin
			r <= n;
		end
	end

	assign led_a.sel       = r.ledsel_reg[`PEV_LEDA_HI - `PEV_LEDB_LO:`PEV_LEDA_LO - `PEV_LEDB_LO];
	assign led_b.sel       = r.ledsel_reg[`PEV_LEDB_HI - `PEV_LEDB_LO:0];
	assign led_a.speed     = speed_100;
	assign led_a.tx        = tx_active;
	assign led_a.rx        = rx_active;
	assign led_a.col       = collision;
	assign led_a.link      = link_up;
	assign led_a.dup       = full_duplex;
	assign led_a.fast_tick = r.fast_tick;
	assign led_a.slow_tick = r.slow_tick;
	assign led_b.speed     = speed_100;
	assign led_b.tx        = tx_active;
	assign led_b.rx        = rx_active;
	assign led_b.col       = collision;
	assign led_b.link      = link_up;
	assign led_b.dup       = full_duplex;
	assign led_b.fast_tick = r.fast_tick;
	assign led_b.slow_tick = r.slow_tick;

	pevirq_led #(.STRETCH_CYC(STRETCH_CYC)) u_led_a (
		.mclk   (mclk),
		.arst_n (arst_n),
		.lif    (led_a)
	);
	pevirq_led #(.STRETCH_CYC(STRETCH_CYC)) u_led_b (
		.mclk   (mclk),
		.arst_n (arst_n),
		.lif    (led_b)
	);

	assign mdio_out     = r.mdio_out;
	assign mdio_oe      = r.mdio_oe;
	assign mgmt_irq_out = r.irq_reg;
	assign indicator_a  = led_a.led_on;
	assign indicator_b  = led_b.led_on;

	logic edge_q;
	assign edge_q = mdc & ~r.mdc_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// interrupt output, one cycle behind flags and mask
	a_irq_disabled: assert property (!r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE]
		&& !r.mask_reg[`PEV_B_FORCE_TEST_IRQ] |=> !mgmt_irq_out) else $error("interrupt while disabled");
	a_irq_forced: assert property (r.mask_reg[`PEV_B_FORCE_TEST_IRQ]
		|=> mgmt_irq_out) else $error("test bit did not force interrupt");
	a_an_gate: assert property (r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE] && r.flags_reg[3]
		&& r.mask_reg[`PEV_B_AN] |=> mgmt_irq_out) else $error("autoneg event not raised");
	a_spd_gate: assert property (r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE] && r.flags_reg[2]
		&& r.mask_reg[`PEV_B_SPD] |=> mgmt_irq_out) else $error("speed event not raised");
	a_dup_gate: assert property (r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE] && r.flags_reg[1]
		&& r.mask_reg[`PEV_B_DUP] |=> mgmt_irq_out) else $error("duplex event not raised");
	a_link_gate: assert property (r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE] && r.flags_reg[0]
		&& r.mask_reg[`PEV_B_LNK] |=> mgmt_irq_out) else $error("link event not raised");
	a_masked_quiet: assert property (!r.mask_reg[`PEV_B_FORCE_TEST_IRQ]
		&& ((r.flags_reg & r.mask_reg[`PEV_EVT_HI:`PEV_EVT_LO]) == 4'h0) |=> !mgmt_irq_out)
		else $error("masked event raised interrupt");
	a_irq_any: assert property (r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE]
		&& ((r.flags_reg & r.mask_reg[`PEV_EVT_HI:`PEV_EVT_LO]) != 4'h0) |=> mgmt_irq_out)
		else $error("enabled flag without interrupt");

	// change flags: set wins, a read clears only what it reported
	a_link_flag_set: assert property ($changed(link_up) |=> r.flags_reg[0])
		else $error("link change not flagged");
	a_speed_flag_set: assert property ($changed(speed_100) |=> r.flags_reg[2])
		else $error("speed change not flagged");
	a_dup_flag_set: assert property ($changed(full_duplex) |=> r.flags_reg[1])
		else $error("duplex change not flagged");
	a_an_flag_set: assert property ($rose(autoneg_done) |=> r.flags_reg[3])
		else $error("autoneg completion not flagged");
	a_flag_hold: assert property (r.flags_reg[0]
		&& !(edge_q && (r.st == pevirq_pkg::S_DATA)) |=> r.flags_reg[0])
		else $error("link flag lost outside a read");
	a_read_clear: assert property (edge_q && (r.st == pevirq_pkg::S_DATA)
		&& (r.cnt == `PEV_DATA_LAST) && r.hit && r.rd && (r.ra == `PEV_REG_FLAGS)
		&& r.snap[0] && (link_up == r.lvl_q[0]) |=> !r.flags_reg[0])
		else $error("link flag not cleared by read");
	a_flag_kept: assert property (edge_q && (r.st == pevirq_pkg::S_DATA)
		&& (r.cnt == `PEV_DATA_LAST) && r.rd && (r.ra == `PEV_REG_FLAGS)
		&& (link_up != r.lvl_q[0]) |=> r.flags_reg[0])
		else $error("link event lost during read");

	// management frame answer and register contents
	a_pend_bit: assert property ((r.st == pevirq_pkg::S_ADDR) && edge_q
		&& (r.cnt == `PEV_ADDR_LAST) && ({r.sh[3:0], mdio_in} == `PEV_REG_FLAGS)
		|=> r.sh[`PEV_B_PEND] == $past(r.irq_reg)) else $error("pending bit not reported");
	a_ta_drive: assert property ((r.st == pevirq_pkg::S_TA) && (r.cnt == 6'h00) && edge_q
		&& r.rd && r.hit |=> mdio_oe && !mdio_out) else $error("read not answered");
	a_mask_unused: assert property ((r.mask_reg & ~`PEV_MASK_WMASK) == 16'h0000)
		else $error("unused mask bit held");
	a_sel_write: assert property (edge_q && (r.st == pevirq_pkg::S_DATA)
		&& (r.cnt == `PEV_DATA_LAST) && r.hit && !r.rd && (r.ra == `PEV_REG_LEDSEL)
		|=> r.ledsel_reg == $past(r.sh[14:7])) else $error("selector write lost");

	c_status_read: cover property (r.hit && r.rd && (r.ra == `PEV_REG_FLAGS) && edge_q
		&& (r.st == pevirq_pkg::S_DATA) && (r.cnt == `PEV_DATA_LAST));
	c_mask_write: cover property ($rose(r.mask_reg[`PEV_B_GLOBAL_IRQ_ENABLE]));
	c_irq_rise: cover property ($rose(mgmt_irq_out) && !r.mask_reg[`PEV_B_FORCE_TEST_IRQ]);
endmodule : pevirq_top
`default_nettype wire

// File: phy_event_irq_and_led_select_tb.sv
// Purpose: self-checking bench of the event interrupt and indicator block
// Assumes: stretch and blink counts shortened through parameters
// Notes:   inputs change on the falling edge of mclk
`timescale 1ns/100ps
`default_nettype none
`include "pevirq_map.svh"
module phy_event_irq_and_led_select_tb;
	localparam int STR = 20;
	localparam int BLK = 8;
	localparam logic [4:0] PA = 5'h05;

	logic       mclk;
	logic       arst_n;
	logic       mdc;
	wire logic  mdio_in;
	logic       mdio_out;
	logic       mdio_oe;
	logic [3:0] ev;
	logic [2:0] act;
	logic       mgmt_irq_out;
	logic       indicator_a;
	logic       indicator_b;
	int         num_errors;
	int         checks_done;

	// ev bit k feeds flag bit 4+k: link, duplex, speed, autoneg
	pevirq_top #(.STRETCH_CYC(STR), .BLINK_CYC(BLK)) i_pevirq_top (
		.mclk(mclk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(PA),
		.link_up(ev[0]), .full_duplex(ev[1]), .speed_100(ev[2]), .autoneg_done(ev[3]),
		.tx_active(act[0]), .rx_active(act[1]), .collision(act[2]),
		.mgmt_irq_out(mgmt_irq_out), .indicator_a(indicator_a), .indicator_b(indicator_b)
	);

	pevirq_mgmt_master i_pevirq_mgmt_master (
		.mclk(mclk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe)
	);

	always #10 mclk = ~mclk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		i_pevirq_mgmt_master.xfer(1'b1, PA, ra, 16'h0000, d);
	endtask : rd

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		i_pevirq_mgmt_master.xfer(1'b0, PA, ra, d, x);
	endtask : wr

	// high for three cycles: two level changes, one rising edge
	task automatic pulse(input int k);
		@(negedge mclk);
		ev[k] = 1'b1;
		cyc(3);
		ev[k] = 1'b0;
		cyc(4);
	endtask : pulse

	task automatic toggles(input int n, output int c);
		logic p;
		c = 0;
		p = indicator_a;
		repeat (n) begin
			@(negedge mclk);
			if (indicator_a !== p) c++;
			p = indicator_a;
		end
	endtask : toggles

	task automatic t_reset();
		logic [15:0] d;
		chk(mgmt_irq_out, 16'h0000, "irq after reset");
		rd(`PEV_REG_MASK, d);
		chk(d & `PEV_MASK_WMASK, `PEV_MASK_RST, "mask reset");
		rd(`PEV_REG_FLAGS, d);
		chk(d, 16'h0000, "flags reset");
		rd(`PEV_REG_LEDSEL, d);
		chk(d, {`PEV_LEDA_RST, `PEV_LEDB_RST, 8'h00}, "select reset");
		$display("test reset done");
	endtask : t_reset

	// flags latch with the global enable off, and a read clears them
	task automatic t_flags();
		logic [15:0] d;
		int          k;
		for (k = 0; k < 4; k++) begin
			pulse(k);
			rd(`PEV_REG_FLAGS, d);
			chk(d, 16'h0010 << k, "flag set");
			chk(mgmt_irq_out, 16'h0000, "irq while disabled");
			rd(`PEV_REG_FLAGS, d);
			chk(d, 16'h0000, "flag cleared");
		end
		$display("test flags done");
	endtask : t_flags

	task automatic t_mask();
		logic [15:0] d;
		int          k;
		for (k = 0; k < 4; k++) begin
			wr(`PEV_REG_MASK, (16'h00f0 & ~(16'h0010 << k)) | 16'h0002);
			pulse(k);
			cyc(5);
			chk(mgmt_irq_out, 16'h0000, "masked event");
			rd(`PEV_REG_FLAGS, d);
			chk(d, 16'h0010 << k, "masked flag");
			wr(`PEV_REG_MASK, (16'h0010 << k) | 16'h0002);
			pulse(k);
			cyc(5);
			chk(mgmt_irq_out, 16'h0001, "enabled event");
			rd(`PEV_REG_FLAGS, d);
			chk(d, (16'h0010 << k) | 16'h0004, "pending flag");
			cyc(5);
			chk(mgmt_irq_out, 16'h0000, "irq after read");
		end
		$display("test mask done");
	endtask : t_mask

	// an event after the snapshot survives the clearing read
	task automatic t_during_read();
		logic [15:0] d;
		fork
			rd(`PEV_REG_FLAGS, d);
			begin
				cyc(330);
				pulse(0);
			end
		join
		chk(d, 16'h0000, "read with late event");
		rd(`PEV_REG_FLAGS, d);
		chk(d, 16'h0010, "late event kept");
		$display("test during read done");
	endtask : t_during_read

	task automatic t_force();
		wr(`PEV_REG_MASK, 16'h0001);
		cyc(3);
		chk(mgmt_irq_out, 16'h0001, "forced irq");
		wr(`PEV_REG_MASK, 16'h0000);
		cyc(3);
		chk(mgmt_irq_out, 16'h0000, "force released");
		$display("test force done");
	endtask : t_force

	// foreign address neither answers nor clears; unmapped reads zero
	task automatic t_refuse();
		logic [15:0] d;
		pulse(0);
		i_pevirq_mgmt_master.xfer(1'b1, PA + 5'h01, `PEV_REG_FLAGS, 16'h0000, d);
		chk(d, 16'hffff, "foreign read");
		rd(5'h1f, d);
		chk(d, 16'h0000, "unmapped read");
		rd(`PEV_REG_FLAGS, d);
		chk(d, 16'h0010, "flag kept");
		$display("test refuse done");
	endtask : t_refuse

	task automatic led_case(input logic [3:0] code, input logic exp);
		wr(`PEV_REG_LEDSEL, {code, code, 8'h00});
		cyc(4);
		chk({indicator_a, indicator_b}, {2{exp}}, "indicator level");
	endtask : led_case

	task automatic stretch_case(input logic [3:0] code, input int b);
		wr(`PEV_REG_LEDSEL, {code, code, 8'h00});
		cyc(4);
		act[b] = 1'b1;
		cyc(1);
		act[b] = 1'b0;
		cyc(STR / 2);
		chk({indicator_a, indicator_b}, 16'h0003, "stretched on");
		cyc(STR + 15);
		chk({indicator_a, indicator_b}, 16'h0000, "stretch over");
	endtask : stretch_case

	task automatic combo_case(input logic [3:0] code, input int b);
		int n;
		wr(`PEV_REG_LEDSEL, {code, code, 8'h00});
		cyc(4);
		act[b] = 1'b1;
		toggles(40, n);
		act[b] = 1'b0;
		chk(n > 2, 16'h0001, "combined blink");
		cyc(STR + 20);
		chk({indicator_a, indicator_b}, 16'h0003, "combined solid");
	endtask : combo_case

	task automatic t_led();
		int f;
		int s;
		ev = 4'b0111;
		led_case(`PEV_LED_SPEED, 1'b1);
		led_case(`PEV_LED_LINK, 1'b1);
		led_case(`PEV_LED_DUP, 1'b1);
		led_case(`PEV_LED_ON, 1'b1);
		led_case(`PEV_LED_OFF, 1'b0);
		led_case(`PEV_LED_UNUSED6, 1'b0);
		led_case(`PEV_LED_UNUSEDF, 1'b0);
		led_case(`PEV_LED_TX, 1'b0);
		ev = 4'b0000;
		led_case(`PEV_LED_SPEED, 1'b0);
		led_case(`PEV_LED_LINK, 1'b0);
		led_case(`PEV_LED_LNKRX, 1'b0);
		stretch_case(`PEV_LED_TX, 0);
		stretch_case(`PEV_LED_RX, 1);
		stretch_case(`PEV_LED_COL, 2);
		stretch_case(`PEV_LED_ACT, 1);
		wr(`PEV_REG_LEDSEL, {`PEV_LED_FAST, `PEV_LED_FAST, 8'h00});
		toggles(160, f);
		wr(`PEV_REG_LEDSEL, {`PEV_LED_SLOW, `PEV_LED_SLOW, 8'h00});
		toggles(160, s);
		chk(f > s && s > 0, 16'h0001, "fast and slow blink");
		ev = 4'b0011;
		combo_case(`PEV_LED_LNKRX, 1);
		combo_case(`PEV_LED_LNKACT, 0);
		combo_case(`PEV_LED_DUPCOL, 2);
		$display("test indicators done");
	endtask : t_led

	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		ev = 4'b0000;
		act = 3'b000;
		num_errors = 0;
		checks_done = 0;
		cyc(2);
		arst_n = 1'b1;
		cyc(2);
		t_reset();
		t_flags();
		t_mask();
		t_during_read();
		t_force();
		t_refuse();
		t_led();
		wrap_up();
	end

	// whole run is near 22000 cycles
	initial begin
		repeat (80000) @(posedge mclk);
		num_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule : phy_event_irq_and_led_select_tb
`default_nettype wire
